//--- inc/run_select_consts.vh
// constants for the run command and preset speed selection block
// assumes a 100 MHz control clock and a 32-bit classic Wishbone bus
`ifndef RUN_SELECT_CONSTS_VH
`define RUN_SELECT_CONSTS_VH

// ==========================================================
// timing
`define CLK_FREQ_MHZ 100
`define DEBOUNCE_TIME_US 1000
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_US * `CLK_FREQ_MHZ)

// ==========================================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FSEL_LO 8'h08
`define REG_FSEL_HI 8'h0C
`define REG_LINK 8'h10
`define REG_PRESET_BASE 8'h20
`define REG_PRESET_LAST 8'h3C

// ==========================================================
// control register fields
`define CTRL_SRC_LSB 0
`define CTRL_FMODE_LSB 4
`define CTRL_KDIR_BIT 8
`define CTRL_INHIBIT_LSB 9
`define CTRL_PWR_AUTO_BIT 11
`define CTRL_FLT_AUTO_BIT 12
`define CTRL_MASK 32'h0000_1FF3
`define CTRL_RESET 32'h0000_0001

// ==========================================================
// link settings register fields
`define LINK_PROT_BIT 0
`define LINK_STATION_LSB 8
`define LINK_BAUD_LSB 16
`define LINK_MASK 32'h0007_FF01
`define LINK_RESET 32'h0003_0100

// ==========================================================
// input function select registers, one byte per input
`define FSEL_MASK 32'h1F1F_1F1F
`define FSEL_LO_RESET 32'h0302_0100
`define FSEL_HI_RESET 32'h0706_0504

// ==========================================================
// status register fields
`define STAT_RUN_BIT 0
`define STAT_REV_BIT 1
`define STAT_REVERSING_BIT 2
`define STAT_BLOCK_BIT 3
`define STAT_STEP_LSB 4
`define STAT_TERM_LSB 8

// ==========================================================
// encodings
`define SRC_KEYPAD 2'h0
`define SRC_TERM_MODE1 2'h1
`define SRC_TERM_MODE2 2'h2
`define SRC_LINK 2'h3
`define FMODE_BIPOLAR 4'h2
`define INHIBIT_NONE 2'h0
`define INHIBIT_FWD 2'h1
`define INHIBIT_REV 2'h2
`define FN_FWD_RUN 5'h00
`define FN_REV_RUN 5'h01
`define FN_STEP_BIT0 5'h05
`define FN_STEP_BIT1 5'h06
`define FN_STEP_BIT2 5'h07

// ==========================================================
// preset table reset values, 0.01 Hz units
`define PRESET0_RESET 16'h0000
`define PRESET1_RESET 16'h03E8
`define PRESET2_RESET 16'h07D0
`define PRESET3_RESET 16'h0BB8
`define PRESET4_RESET 16'h0BB8
`define PRESET5_RESET 16'h09C4
`define PRESET6_RESET 16'h07D0
`define PRESET7_RESET 16'h05DC

`endif

//--- rtl/preset_speed_table.v
// eight-word table of step frequencies with registered read data
// assumes one clock domain; write and read ports are independent
`timescale 1ns/1ps
`default_nettype none
`include "run_select_consts.vh"

module preset_speed_table #(
  parameter FREQ_WIDTH = 16
) (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // write port
  input wire wr_en_i,
  input wire [2:0] wr_addr_i,
  input wire [FREQ_WIDTH-1:0] wr_data_i,
  input wire [1:0] wr_be_i,
  // read port
  input wire [2:0] rd_addr_i,
  output reg [FREQ_WIDTH-1:0] rd_data_o
);

  reg [FREQ_WIDTH-1:0] mem [0:7];
  integer k;

  function [15:0] reset_word;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: reset_word = `PRESET0_RESET;
        3'h1: reset_word = `PRESET1_RESET;
        3'h2: reset_word = `PRESET2_RESET;
        3'h3: reset_word = `PRESET3_RESET;
        3'h4: reset_word = `PRESET4_RESET;
        3'h5: reset_word = `PRESET5_RESET;
        3'h6: reset_word = `PRESET6_RESET;
        default: reset_word = `PRESET7_RESET;
      endcase
    end
  endfunction

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (k = 0; k < 8; k = k + 1) begin
        mem[k] <= reset_word(k[2:0]);
      end
      rd_data_o <= {FREQ_WIDTH{1'b0}};
    end else begin
      if (wr_en_i) begin
        if (wr_be_i[0]) begin
          mem[wr_addr_i][7:0] <= wr_data_i[7:0];
        end
        if (wr_be_i[1]) begin
          mem[wr_addr_i][FREQ_WIDTH-1:8] <= wr_data_i[FREQ_WIDTH-1:8];
        end
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule // preset_speed_table
`default_nettype wire

//--- rtl/run_command_step_select.v
// run command, direction and preset speed step selection
// assumes terminal and keypad pins are asynchronous; fault, link and
// motor-stopped signals come from logic on the same clock
//
// Summary of operation
// - any of the eight inputs may be a step select bit
// - codes five to seven make an input step bits zero to two
// - step zero uses preset speed word zero of the table
// - steps one to seven use the preset speed words
// - keypad mode: run key starts if frequency set, stop key stops
// - keypad direction setting picks forward or reverse
// - remote keypad, when present, replaces the built-in keypad
// - terminal mode one: forward input runs forward, reverse runs reverse
// - terminal mode one: both inputs on or both off means stop
// - terminal mode two: forward input runs, reverse input sets direction
// - link mode: run and direction come from the serial link
// - bipolar frequency mode: negative input inverts the direction
// - direction change while running: decelerate to stop, then reverse
// - inhibit: zero allows both, one blocks forward, two blocks reverse
// - power-on autostart runs if the terminal is on at power-up
// - fault autorestart runs if the terminal is on at fault clear
// - autostart functions do nothing in keypad or link mode
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "run_select_consts.vh"

module run_command_step_select #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter FREQ_WIDTH = 16
) (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // control terminals and keypads (pins)
  input wire [7:0] terminal_i,
  input wire run_key_i,
  input wire stop_key_i,
  input wire remote_run_key_i,
  input wire remote_stop_key_i,
  input wire remote_keypad_present_i,
  input wire bipolar_negative_i,
  // drive-internal status
  input wire fault_i,
  input wire motor_stopped_i,
  input wire link_run_i,
  input wire link_reverse_i,
  // run command out
  output wire run_o,
  output reg reverse_o,
  output wire reversing_o,
  output reg [2:0] step_index_o,
  output reg [FREQ_WIDTH-1:0] step_freq_o,
  output wire [3:0] freq_mode_o,
  // serial link settings
  output wire link_protocol_select_o,
  output wire [7:0] station_number_o,
  output wire [2:0] link_baud_select_o
);

  localparam CW = $clog2(DEBOUNCE_CYCLES + 4);
  localparam [CW-1:0] DB_LAST = DEBOUNCE_CYCLES - 1;
  localparam [CW-1:0] SETTLE_LAST = DEBOUNCE_CYCLES + 3;
  localparam NPIN = 14;

  // one-hot run states
  localparam [2:0] ST_STOP = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_REVERSAL = 3'b100;

  // ==========================================================
  // registers
  reg [31:0] ctrl_reg;
  reg [31:0] link_reg;
  reg [31:0] fsel_lo;
  reg [31:0] fsel_hi;

  wire [1:0] run_source = ctrl_reg[`CTRL_SRC_LSB +: 2];
  wire keypad_direction_select = ctrl_reg[`CTRL_KDIR_BIT];
  wire [1:0] direction_inhibit = ctrl_reg[`CTRL_INHIBIT_LSB +: 2];
  wire power_on_autostart = ctrl_reg[`CTRL_PWR_AUTO_BIT];
  wire fault_reset_autorestart = ctrl_reg[`CTRL_FLT_AUTO_BIT];
  wire [63:0] fsel_all = {fsel_hi, fsel_lo};

  assign freq_mode_o = ctrl_reg[`CTRL_FMODE_LSB +: 4];
  assign link_protocol_select_o = link_reg[`LINK_PROT_BIT];
  assign station_number_o = link_reg[`LINK_STATION_LSB +: 8];
  assign link_baud_select_o = link_reg[`LINK_BAUD_LSB +: 3];

  function [31:0] byte_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer b;
    begin
      byte_merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          byte_merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire [NPIN-1:0] pins = {bipolar_negative_i, remote_keypad_present_i,
    remote_stop_key_i, remote_run_key_i, stop_key_i, run_key_i,
    terminal_i};
  reg [NPIN-1:0] sync_a;
  reg [NPIN-1:0] sync_b;
  reg [3:0] key_q;

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= {NPIN{1'b0}};
      sync_b <= {NPIN{1'b0}};
      key_q <= 4'h0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      key_q <= sync_b[11:8];
    end
  end

  wire [3:0] key_press = sync_b[11:8] & ~key_q;
  wire remote_present = sync_b[12];
  wire bipolar_negative = sync_b[13];

  // ==========================================================
  // terminal debouncers: a level must hold for the full count
  wire [7:0] term_filt;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_db
      reg [CW-1:0] cnt;
      reg filt;
      assign term_filt[gi] = filt;
      always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt <= {CW{1'b0}};
          filt <= 1'b0;
        end else if (sync_b[gi] == filt) begin
          cnt <= {CW{1'b0}};
        end else if (cnt == DB_LAST) begin
          cnt <= {CW{1'b0}};
          filt <= sync_b[gi];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

  // filters start low, so no terminal is trusted until one full
  // debounce window and three more cycles have passed after reset
  reg [CW-1:0] settle_cnt;
  wire settled = (settle_cnt == SETTLE_LAST);

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_cnt <= {CW{1'b0}};
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 1'b1;
    end
  end

  // ==========================================================
  // input function decode
  reg [2:0] next_step;
  reg fwd_in;
  reg rev_in;
  reg [4:0] code;
  integer k;

  always @* begin
    next_step = 3'b000;
    fwd_in = 1'b0;
    rev_in = 1'b0;
    code = 5'h00;
    for (k = 0; k < 8; k = k + 1) begin
      code = fsel_all[k*8 +: 5];
      if (term_filt[k]) begin
        case (code)
          `FN_FWD_RUN: fwd_in = 1'b1;
          `FN_REV_RUN: rev_in = 1'b1;
          `FN_STEP_BIT0: next_step[0] = 1'b1;
          `FN_STEP_BIT1: next_step[1] = 1'b1;
          `FN_STEP_BIT2: next_step[2] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // run source selection
  wire term_mode = (run_source == `SRC_TERM_MODE1) ||
    (run_source == `SRC_TERM_MODE2);
  wire term_run = (run_source == `SRC_TERM_MODE1) ?
    (fwd_in ^ rev_in) : fwd_in;
  wire kp_run_press = remote_present ? key_press[2] : key_press[0];
  wire kp_stop_press = remote_present ? key_press[3] : key_press[1];

  reg kp_run;
  reg term_block;
  reg por_done;
  reg fault_q;
  wire fault_cleared = fault_q & ~fault_i;

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      kp_run <= 1'b0;
    end else if (kp_stop_press || fault_i ||
        run_source != `SRC_KEYPAD) begin
      kp_run <= 1'b0;
    end else if (kp_run_press && step_freq_o != {FREQ_WIDTH{1'b0}}) begin
      kp_run <= 1'b1;
    end
  end

  // a terminal that is on at power-up or fault clear is held off until
  // seen off, unless the matching autostart is enabled; the power-on
  // choice waits for the settle window so software can set autostart
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_done <= 1'b0;
      term_block <= 1'b1;
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_i;
      if (!por_done) begin
        por_done <= settled;
        if (settled) begin
          term_block <= ~(power_on_autostart & term_mode);
        end
      end else if (fault_cleared) begin
        term_block <= ~(fault_reset_autorestart & term_mode);
      end else if (settled && !term_run) begin
        term_block <= 1'b0;
      end
    end
  end

  reg cmd_run;
  reg cmd_rev;

  always @* begin
    case (run_source)
      `SRC_KEYPAD: begin
        cmd_run = kp_run;
        cmd_rev = keypad_direction_select;
      end
      `SRC_TERM_MODE1: begin
        cmd_run = term_run & ~term_block;
        cmd_rev = rev_in;
      end
      `SRC_TERM_MODE2: begin
        cmd_run = term_run & ~term_block;
        cmd_rev = rev_in;
      end
      default: begin
        cmd_run = link_run_i;
        cmd_rev = link_reverse_i;
      end
    endcase
  end

  wire dir_final = cmd_rev ^
    (freq_mode_o == `FMODE_BIPOLAR && bipolar_negative);
  wire inhibited =
    (direction_inhibit == `INHIBIT_FWD && !dir_final) ||
    (direction_inhibit == `INHIBIT_REV && dir_final);
  wire run_ok = cmd_run & ~fault_i & ~inhibited;

  // ==========================================================
  // run state machine
  reg [2:0] state;

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_STOP;
      reverse_o <= 1'b0;
      step_index_o <= 3'b000;
    end else begin
      step_index_o <= next_step;
      case (state)
        ST_STOP: begin
          if (run_ok) begin
            state <= ST_RUN;
            reverse_o <= dir_final;
          end
        end
        ST_RUN: begin
          if (!run_ok) begin
            state <= ST_STOP;
          end else if (dir_final != reverse_o) begin
            state <= ST_REVERSAL;
          end
        end
        ST_REVERSAL: begin
          // old direction stays on the output until the motor rests
          if (motor_stopped_i) begin
            if (run_ok) begin
              state <= ST_RUN;
              reverse_o <= dir_final;
            end else begin
              state <= ST_STOP;
            end
          end
        end
        default: state <= ST_STOP;
      endcase
    end
  end

  assign run_o = state[1];
  assign reversing_o = state[2];

  // ==========================================================
  // wishbone slave: ack two cycles after the request, write at the ack
  wire req = wb_cyc_i & wb_stb_i;
  wire preset_hit = (wb_adr_i >= `REG_PRESET_BASE) &&
    (wb_adr_i <= `REG_PRESET_LAST) && (wb_adr_i[1:0] == 2'b00);
  wire bus_rd_mem = req & preset_hit & ~wb_we_i;
  wire wr_now = req & wb_ack_o & wb_we_i;
  wire [2:0] mem_raddr = bus_rd_mem ? wb_adr_i[4:2] : step_index_o;
  wire [FREQ_WIDTH-1:0] mem_rdata;
  reg pend;
  reg rd_was_step;

  preset_speed_table #(
    .FREQ_WIDTH(FREQ_WIDTH)
  ) u_table (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(wr_now & preset_hit),
    .wr_addr_i(wb_adr_i[4:2]),
    .wr_data_i(wb_dat_i[FREQ_WIDTH-1:0]),
    .wr_be_i(wb_sel_i[1:0]),
    .rd_addr_i(mem_raddr),
    .rd_data_o(mem_rdata)
  );

  wire [31:0] status_word = {16'h0000, term_filt, 1'b0, step_index_o,
    term_block, state[2], reverse_o, state[1]};
  reg [31:0] rd_mux;

  always @* begin
    case (wb_adr_i)
      `REG_CTRL: rd_mux = ctrl_reg & `CTRL_MASK;
      `REG_STATUS: rd_mux = status_word;
      `REG_FSEL_LO: rd_mux = fsel_lo & `FSEL_MASK;
      `REG_FSEL_HI: rd_mux = fsel_hi & `FSEL_MASK;
      `REG_LINK: rd_mux = link_reg & `LINK_MASK;
      default: begin
        rd_mux = 32'h0000_0000;
        if (preset_hit) begin
          rd_mux[FREQ_WIDTH-1:0] = mem_rdata;
        end
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      rd_was_step <= 1'b0;
      step_freq_o <= {FREQ_WIDTH{1'b0}};
    end else begin
      pend <= req & ~pend & ~wb_ack_o;
      wb_ack_o <= req & pend;
      if (req && pend) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
      end
      // table port is shared; keep the last step value during bus reads
      rd_was_step <= ~bus_rd_mem;
      if (rd_was_step) begin
        step_freq_o <= mem_rdata;
      end
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= `CTRL_RESET;
      link_reg <= `LINK_RESET;
      fsel_lo <= `FSEL_LO_RESET;
      fsel_hi <= `FSEL_HI_RESET;
    end else if (wr_now) begin
      case (wb_adr_i)
        `REG_CTRL: ctrl_reg <= byte_merge(ctrl_reg, wb_dat_i, wb_sel_i);
        `REG_LINK: link_reg <= byte_merge(link_reg, wb_dat_i, wb_sel_i);
        `REG_FSEL_LO: fsel_lo <= byte_merge(fsel_lo, wb_dat_i, wb_sel_i);
        `REG_FSEL_HI: fsel_hi <= byte_merge(fsel_hi, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

endmodule // run_command_step_select
`default_nettype wire

//--- verif/drive_panel_model.sv
// terminal wiring with contact chatter, plus a motor that coasts to rest
// assumes one clock; level_i is the settled switch position
`timescale 1ns/1ps
`default_nettype none
module drive_panel_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // switch positions and run command
  input wire logic [7:0] level_i,
  input wire logic run_i,
  // pins seen by the drive
  output logic [7:0] terminal_o,
  output logic motor_stopped_o
);
  logic [7:0] prev;
  logic [7:0] diff;
  logic [1:0] chat;
  logic [2:0] idle;
  // ========
  // switches: changed contacts chatter for three cycles
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= level_i;
      diff <= 8'h00;
      chat <= 2'h0;
      terminal_o <= level_i;
    end else begin
      prev <= level_i;
      if (level_i != prev) begin
        diff <= level_i ^ prev;
        chat <= 2'h3;
      end else if (chat != 2'h0) begin
        chat <= chat - 2'h1;
      end
      terminal_o <= chat[0] ? level_i ^ diff : level_i;
    end
  end
  // ========
  // motor: at rest four cycles after the run command goes away
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle <= 3'h4;
    end else if (run_i) begin
      idle <= 3'h0;
    end else if (idle != 3'h4) begin
      idle <= idle + 3'h1;
    end
  end
  assign motor_stopped_o = idle == 3'h4;
endmodule // drive_panel_model
`default_nettype wire

//--- verif/run_select_assertions.sv
// port checker for the run selection block
// assumes it is bound onto every run_command_step_select
`timescale 1ns/1ps
`default_nettype none
`include "run_select_consts.vh"
module run_select_checker (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // drive side
  input wire fault_i,
  input wire motor_stopped_i,
  input wire run_o,
  input wire reverse_o,
  input wire reversing_o
);
  logic [1:0] inh;
  logic [1:0] age;
  wire req = wb_cyc_i && wb_stb_i;
  // shadow inhibit field, aged so the decode has settled
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inh <= 2'h0;
      age <= 2'h0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == `REG_CTRL
                 && wb_sel_i[1]) begin
      inh <= wb_dat_i[`CTRL_INHIBIT_LSB+:2];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ========
  // assertions
  ack_delay_a: assert property (req && !$past(req) |-> ##[2:3] wb_ack_o)
    else $error("bus answer late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_req_a: assert property (wb_ack_o |-> req)
    else $error("ack without request");
  fault_stop_a: assert property (fault_i [*3] |-> !run_o)
    else $error("running during fault");
  inh_fwd_a: assert property (run_o && age == 2'h3
    && inh == `INHIBIT_FWD |-> reverse_o) else $error("forward not blocked");
  inh_rev_a: assert property (run_o && age == 2'h3
    && inh == `INHIBIT_REV |-> !reverse_o) else $error("reverse not blocked");
  dir_hold_a: assert property ($changed(reverse_o) |-> !$past(run_o))
    else $error("direction flipped while running");
  swap_idle_a: assert property (reversing_o |-> !run_o)
    else $error("running while reversing");
  swap_resume_a: assert property (reversing_o && motor_stopped_i
    && !fault_i |-> ##[1:2] run_o) else $error("no restart after stop");
  cover property ($rose(reversing_o));
  cover property (run_o && reverse_o);
  cover property (wb_ack_o && !wb_we_i);
endmodule // run_select_checker
bind run_command_step_select run_select_checker u_chk (.sys_clk_i,
  .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .fault_i, .motor_stopped_i, .run_o, .reverse_o, .reversing_o);
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the run selection block
// assumes the panel model drives the terminals and motor-stopped
`timescale 1ns/1ps
`default_nettype none
`include "run_select_consts.vh"
module tb_top;
  localparam int DEB = 4;
  // chatter, sync, filter and one reversal fit inside this wait
  localparam int SETTLE = 40;
  logic clk;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] keys = 4'h0;
  logic [7:0] level = 8'h00;
  logic rpres = 1'b0;
  logic neg = 1'b0;
  logic fault = 1'b0;
  logic lrun = 1'b0;
  logic lrev = 1'b0;
  logic saw_swap = 1'b0;
  logic [15:0] pr [0:7] = '{`PRESET0_RESET, `PRESET1_RESET, `PRESET2_RESET,
    `PRESET3_RESET, `PRESET4_RESET, `PRESET5_RESET, `PRESET6_RESET,
    `PRESET7_RESET};
  wire [31:0] rdat;
  wire ack, stopped, run, rev, swap, lprot;
  wire [7:0] term, lstat;
  wire [2:0] step, lbaud;
  wire [15:0] freq;
  wire [3:0] fmode;
  int num_errors = 0;
  int check_count = 0;

  run_command_step_select #(.DEBOUNCE_CYCLES(DEB)) u_dut (.sys_clk_i(clk),
    .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .terminal_i(term), .run_key_i(keys[0]),
    .stop_key_i(keys[1]), .remote_run_key_i(keys[2]),
    .remote_stop_key_i(keys[3]), .remote_keypad_present_i(rpres),
    .bipolar_negative_i(neg), .fault_i(fault), .motor_stopped_i(stopped),
    .link_run_i(lrun), .link_reverse_i(lrev), .run_o(run),
    .reverse_o(rev), .reversing_o(swap), .step_index_o(step),
    .step_freq_o(freq), .freq_mode_o(fmode),
    .link_protocol_select_o(lprot), .station_number_o(lstat),
    .link_baud_select_o(lbaud));
  drive_panel_model u_panel (.sys_clk_i(clk), .nrst_i(nrst),
    .level_i(level), .run_i(run), .terminal_o(term),
    .motor_stopped_o(stopped));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (swap) saw_swap <= 1'b1;

  // ========
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // reverse only matters while running
  task automatic drv(input logic [31:0] exp);
    chk({30'h0, rev & run, run}, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    wt(12);
    nrst <= 1'b1;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hf);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(q, e);
  endtask
  task automatic set_term(input logic [7:0] v);
    @(posedge clk);
    level <= v;
    wt(SETTLE);
  endtask
  task automatic press(input int b);
    @(posedge clk);
    keys[b] <= 1'b1;
    wt(4);
    keys[b] <= 1'b0;
    wt(12);
  endtask
  task automatic trip();
    @(posedge clk);
    fault <= 1'b1;
    wt(4);
    fault <= 1'b0;
    wt(8);
  endtask

  // ========
  // scenarios
  task automatic s_regs();
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_FSEL_LO, `FSEL_LO_RESET);
    rd(`REG_FSEL_HI, `FSEL_HI_RESET);
    for (int i = 0; i < 8; i++) rd(8'h20 + 8'(4 * i), {16'h0, pr[i]});
    wr(8'h20, 32'h0000_1234, 4'h1);
    rd(8'h20, 32'h0000_0034);
    wr(8'h20, 32'h0000_1234);
    pr[0] = 16'h1234;
    wr(`REG_LINK, 32'hFFFF_FFFF);
    rd(`REG_LINK, `LINK_MASK);
    chk({20'h0, lprot, lstat, lbaud}, 32'h0000_0FFF);
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000);
  endtask
  task automatic s_steps();
    for (int i = 0; i < 8; i++) begin
      set_term({i[2:0], 5'h01});
      chk({29'h0, step}, 32'(i));
      chk({16'h0, freq}, {16'h0, pr[i]});
      drv(32'h0000_0001);
    end
    wr(`REG_FSEL_LO, 32'h0005_0000, 4'h4);
    set_term(8'h05);
    chk({16'h0, freq}, {16'h0, pr[1]});
    wr(`REG_FSEL_LO, 32'h0302_0100);
    set_term(8'h00);
    @(posedge clk);
    level <= 8'h01;
    wt(2);
    level <= 8'h00;
    wt(SETTLE);
    drv(32'h0000_0000);
  endtask
  task automatic s_terms();
    set_term(8'h01);
    set_term(8'h02);
    drv(32'h0000_0003);
    chk({31'h0, saw_swap}, 32'h0000_0001);
    set_term(8'h03);
    drv(32'h0000_0000);
    wr(`REG_CTRL, 32'h0000_0002);
    set_term(8'h01);
    drv(32'h0000_0001);
    set_term(8'h03);
    drv(32'h0000_0003);
    set_term(8'h02);
    drv(32'h0000_0000);
    wr(`REG_CTRL, 32'h0000_0201);
    set_term(8'h01);
    drv(32'h0000_0000);
    set_term(8'h02);
    drv(32'h0000_0003);
    wr(`REG_CTRL, 32'h0000_0401);
    wt(2);
    drv(32'h0000_0000);
    set_term(8'h01);
    drv(32'h0000_0001);
    set_term(8'h00);
  endtask
  task automatic s_keypad();
    wr(`REG_CTRL, 32'h0000_0000);
    press(0);
    drv(32'h0000_0001);
    press(1);
    drv(32'h0000_0000);
    wr(`REG_CTRL, 32'h0000_0100);
    press(0);
    drv(32'h0000_0003);
    rpres <= 1'b1;
    press(1);
    drv(32'h0000_0003);
    press(3);
    drv(32'h0000_0000);
    press(0);
    drv(32'h0000_0000);
    press(2);
    drv(32'h0000_0003);
    press(3);
    rpres <= 1'b0;
    wr(8'h20, 32'h0000_0000);
    press(0);
    drv(32'h0000_0000);
    wr(8'h20, 32'h0000_1234);
  endtask
  task automatic s_link_bipolar();
    wr(`REG_CTRL, 32'h0000_0003);
    lrun <= 1'b1;
    lrev <= 1'b1;
    wt(SETTLE);
    drv(32'h0000_0003);
    lrev <= 1'b0;
    wt(SETTLE);
    drv(32'h0000_0001);
    lrun <= 1'b0;
    wr(`REG_CTRL, 32'h0000_0021);
    wt(2);
    chk({28'h0, fmode}, 32'h0000_0002);
    set_term(8'h01);
    neg <= 1'b1;
    wt(SETTLE);
    drv(32'h0000_0003);
    set_term(8'h02);
    drv(32'h0000_0001);
    neg <= 1'b0;
    set_term(8'h01);
  endtask
  task automatic s_auto();
    rst();
    wr(`REG_CTRL, 32'h0000_0801);
    wt(SETTLE);
    drv(32'h0000_0001);
    rst();
    wt(SETTLE);
    drv(32'h0000_0000);
    set_term(8'h00);
    set_term(8'h01);
    drv(32'h0000_0001);
    wr(`REG_CTRL, 32'h0000_1001);
    trip();
    drv(32'h0000_0001);
    wr(`REG_CTRL, 32'h0000_0001);
    trip();
    drv(32'h0000_0000);
    rst();
    wr(`REG_CTRL, 32'h0000_1800);
    wt(SETTLE);
    drv(32'h0000_0000);
    trip();
    drv(32'h0000_0000);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    rst();
    s_regs();
    s_steps();
    s_terms();
    s_keypad();
    s_link_bipolar();
    s_auto();
    finish_test();
  end
  // whole run needs under two thousand cycles
  initial begin
    wt(20000);
    num_errors++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
